//--- include/sfsp_pkg.sv
package sfsp_pkg;

   // geometry of the array: 256K words of four 9-bit lanes
   localparam int ADDR_W  = 18;
   localparam int DEPTH   = 262144;
   localparam int LANES   = 4;
   localparam int BYTE_W  = 8;
   localparam int LANE_W  = 9;
   localparam int DATA_W  = 32;
   localparam int BURST_W = 2;

   // reset values
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic               ORDER_RST = 1'h1;   // interleaved, as a floating strap

   // strap encoding
   localparam logic ORDER_LINEAR = 1'h0;

   // one stored word, lane i holds {parity bit, data byte}
   typedef logic [LANES-1:0][LANE_W-1:0] sfsp_word_t;

   // write waiting for its data phase
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lanes;
   } sfsp_wr_t;

   localparam sfsp_wr_t WR_RST = '{valid: 1'b0, addr: '0, lanes: '0};

   // access kind of the running burst
   typedef enum logic [1:0] {
      SFSP_IDLE,
      SFSP_READ,
      SFSP_WRITE
   } sfsp_state_t;

endpackage

//--- verilog/sfsp_mem.sv
module sfsp_mem (
   // clock and reset
   input  wire logic                            i_clk,
   input  wire logic                            i_arst_n,
   // write port, lanes already qualified
   input  wire logic                            i_we,
   input  wire logic [sfsp_pkg::ADDR_W-1:0]     i_waddr,
   input  wire logic [sfsp_pkg::LANES-1:0]      i_wlanes,
   input  wire sfsp_pkg::sfsp_word_t            i_wdata,
   // read port, result valid after the edge
   input  wire logic                            i_re,
   input  wire logic [sfsp_pkg::ADDR_W-1:0]     i_raddr,
   output sfsp_pkg::sfsp_word_t                 o_rdata
);

   sfsp_pkg::sfsp_word_t mem [0:sfsp_pkg::DEPTH-1];
   sfsp_pkg::sfsp_word_t rdata_q;
   sfsp_pkg::sfsp_word_t rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // read with forwarding of lanes written in the same edge
   always_comb
   begin
      rdata_d = rdata_q;
      if (i_re)
      begin
         rdata_d = mem[i_raddr];
         for (int i = 0; i < sfsp_pkg::LANES; i++)
         begin
            // new data wins, else a write-then-read pair returns stale lanes
            if (i_we && i_wlanes[i] && (i_waddr == i_raddr))
            begin
               rdata_d[i] = i_wdata[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array itself has no reset, contents survive sleep
   always_ff @(posedge i_clk)
   begin
      for (int i = 0; i < sfsp_pkg::LANES; i++)
      begin
         if (i_we && i_wlanes[i])
         begin
            mem[i_waddr][i] <= i_wdata[i];
         end
      end
   end

   assign o_rdata = rdata_q;

endmodule

//--- verilog/sfsp_port.sv
// How it works
// RULE_01 - address is taken at the qualified edge and picks one of 256K words
// RULE_02 - the two low address bits seed a two-bit burst counter
// RULE_03 - active-low lane write selects are sampled each edge, only with write
// RULE_04 - the write strobe is sampled only when clock gate is low
// RULE_05 - controller drives write strobe low to write, high to read
// RULE_06 - advance high with clock gate low steps the burst counter
// RULE_07 - advance low at a qualified edge loads a new start address
// RULE_08 - after deselect the controller should load a fresh address
// RULE_09 - edges with clock gate high are ignored entirely; the strap flop order_q still samples its pin on them
// RULE_10 - clock gate high freezes all state, extending the previous cycle; the strap flop order_q is not frozen
// RULE_11 - selected only with first select low, high select high, second low
// RULE_12 - output enable low lets the data pins drive, high makes them inputs
// RULE_13 - no drive during write data, first cycle after deselect, or deselect
// RULE_14 - sleep freezes the port and drops drive, contents are kept; order_q still follows the strap
// RULE_15 - burst order strap low is linear, high or floating interleaved
// RULE_16 - read data appears in the cycle right after the address edge
// RULE_17 - parity pins act like data pins, gated by their lane select
// RULE_18 - burst wraps inside four words, upper address bits never change
// RULE_19 - write data is taken at the edge after its address edge
module sfsp_port (
   // clock and reset
   input  wire logic                            i_clk,
   input  wire logic                            i_arst_n,
   // address and access control
   input  wire logic [sfsp_pkg::ADDR_W-1:0]     i_addr,
   input  wire logic                            i_write_n,
   input  wire logic                            i_burst_step_or_load,
   input  wire logic                            i_clock_gate_n,
   input  wire logic [sfsp_pkg::LANES-1:0]      i_byte_write_n,
   // chip selects
   input  wire logic                            i_chip_select_low_first,
   input  wire logic                            i_chip_select_high,
   input  wire logic                            i_chip_select_low_second,
   // asynchronous controls and strap
   input  wire logic                            i_out_enable_n,
   input  wire logic                            i_sleep_request,
   input  wire logic                            i_burst_order,
   // data pins, split into in, out and enable
   input  wire logic [sfsp_pkg::DATA_W-1:0]     i_dq,
   output logic      [sfsp_pkg::DATA_W-1:0]     o_dq,
   output logic                                 o_dq_oe,
   // parity pins, split into in, out and enable
   input  wire logic [sfsp_pkg::LANES-1:0]      i_parity_io,
   output logic      [sfsp_pkg::LANES-1:0]      o_parity_io,
   output logic                                 o_parity_io_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // low address bits for step n of a burst started at s
   function automatic logic [sfsp_pkg::BURST_W-1:0] burst_low(
      input logic [sfsp_pkg::BURST_W-1:0] s,
      input logic [sfsp_pkg::BURST_W-1:0] n,
      input logic                         order
   );
      logic [sfsp_pkg::BURST_W-1:0] r;
      r = 2'h0;
      if (order == sfsp_pkg::ORDER_LINEAR)
      begin
         r = s + n;   // wraps in two bits by width
      end
      else
      begin
         r = s ^ n;
      end
      return r;
   endfunction

   // pins to lane-packed word
   function automatic sfsp_pkg::sfsp_word_t pack_word(
      input logic [sfsp_pkg::DATA_W-1:0] d,
      input logic [sfsp_pkg::LANES-1:0]  p
   );
      sfsp_pkg::sfsp_word_t w;
      w = '0;
      for (int i = 0; i < sfsp_pkg::LANES; i++)
      begin
         w[i] = {p[i], d[i*sfsp_pkg::BYTE_W +: sfsp_pkg::BYTE_W]};
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   sfsp_pkg::sfsp_state_t                state_q;
   sfsp_pkg::sfsp_state_t                state_d;
   logic [sfsp_pkg::ADDR_W-1:0]          base_q;
   logic [sfsp_pkg::ADDR_W-1:0]          base_d;
   logic [sfsp_pkg::BURST_W-1:0]         cnt_q;
   logic [sfsp_pkg::BURST_W-1:0]         cnt_d;
   sfsp_pkg::sfsp_wr_t                   pend_q;
   sfsp_pkg::sfsp_wr_t                   pend_d;
   logic                                 drive_q;
   logic                                 drive_d;
   logic                                 order_q;

   logic                                 go;
   logic                                 selected;
   logic                                 access;
   logic [sfsp_pkg::BURST_W-1:0]         step;
   logic [sfsp_pkg::ADDR_W-1:0]          acc_addr;
   logic                                 mem_we;
   logic                                 mem_re;
   sfsp_pkg::sfsp_word_t                 wdata;
   sfsp_pkg::sfsp_word_t                 rdata;

   ////////////////////////////////////////////////////////////////////////////
   // edge qualification

   // RULE_09 edge gating
   // RULE_14 sleep freezes
   // sleep acts at once; an edge seen while asleep only updates the strap flop order_q
   assign go = !i_clock_gate_n && !i_sleep_request;

   // RULE_11 select decode
   assign selected = !i_chip_select_low_first && i_chip_select_high
                     && !i_chip_select_low_second;

   assign step = cnt_q + 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // access sequencer, next values
   always_comb
   begin
      state_d  = state_q;
      base_d   = base_q;
      cnt_d    = cnt_q;
      pend_d   = pend_q;
      drive_d  = drive_q;
      access   = 1'b0;
      acc_addr = base_q;
      mem_we   = 1'b0;
      mem_re   = 1'b0;
      // RULE_10 hold on gate
      // nothing below moves unless the edge is qualified
      if (go)
      begin
         // RULE_19 write data phase
         mem_we        = pend_q.valid;
         pend_d.valid  = 1'b0;
         drive_d       = 1'b0;
         if (!selected)
         begin
            state_d = sfsp_pkg::SFSP_IDLE;
         end
         else if (!i_burst_step_or_load)
         begin
            // RULE_07 load new address
            // RULE_04 strobe sampled here
            // RULE_01 full address taken
            access   = 1'b1;
            acc_addr = i_addr;
            base_d   = i_addr;
            // RULE_02 counter seeded
            cnt_d    = sfsp_pkg::BURST_RST;
            state_d  = i_write_n ? sfsp_pkg::SFSP_READ : sfsp_pkg::SFSP_WRITE;
         end
         else if (state_q != sfsp_pkg::SFSP_IDLE)
         begin
            // RULE_06 advance burst
            // RULE_18 wrap in block
            access   = 1'b1;
            cnt_d    = step;
            acc_addr = {base_q[sfsp_pkg::ADDR_W-1:sfsp_pkg::BURST_W],
                        burst_low(base_q[sfsp_pkg::BURST_W-1:0], step, order_q)};
         end
         // advance while idle is a no-op, nothing to continue
         if (access && (state_d == sfsp_pkg::SFSP_READ))
         begin
            // RULE_16 flow-through read
            mem_re  = 1'b1;
            drive_d = 1'b1;
         end
         if (access && (state_d == sfsp_pkg::SFSP_WRITE))
         begin
            // RULE_03 lane selects
            pend_d.valid = 1'b1;
            pend_d.addr  = acc_addr;
            pend_d.lanes = ~i_byte_write_n;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_q <= sfsp_pkg::SFSP_IDLE;
         base_q  <= '0;
         cnt_q   <= sfsp_pkg::BURST_RST;
         pend_q  <= sfsp_pkg::WR_RST;
         drive_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         base_q  <= base_d;
         cnt_q   <= cnt_d;
         pend_q  <= pend_d;
         drive_q <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strap, followed after reset; the pin is static in use
   // RULE_15 order strap
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         order_q <= sfsp_pkg::ORDER_RST;
      end
      else
      begin
         order_q <= i_burst_order;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage

   // RULE_17 parity in lanes
   assign wdata = pack_word(i_dq, i_parity_io);

   sfsp_mem u_mem (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_we     (mem_we),
      .i_waddr  (pend_q.addr),
      .i_wlanes (pend_q.lanes),
      .i_wdata  (wdata),
      .i_re     (mem_re),
      .i_raddr  (acc_addr),
      .o_rdata  (rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin drive

   // unpack read word onto data and parity pins, straight from the read flop
   always_comb
   begin
      o_dq        = '0;
      o_parity_io = '0;
      for (int i = 0; i < sfsp_pkg::LANES; i++)
      begin
         o_dq[i*sfsp_pkg::BYTE_W +: sfsp_pkg::BYTE_W] = rdata[i][sfsp_pkg::BYTE_W-1:0];
         o_parity_io[i] = rdata[i][sfsp_pkg::BYTE_W];
      end
   end

   // RULE_12 output enable
   // RULE_13 self-timed float
   // drive_q is set by a read edge and held until the next qualified edge, so write data,
   // deselect and the cycle leaving deselect never drive
   assign o_dq_oe        = drive_q && !i_out_enable_n && !i_sleep_request;
   assign o_parity_io_oe = o_dq_oe;

endmodule

//--- test/sfsp_port_monitor.sv
module sfsp_port_monitor (
   // watched inputs
   input wire logic                        i_clk,
   input wire logic                        i_arst_n,
   input wire logic                        i_write_n,
   input wire logic                        i_burst_step_or_load,
   input wire logic                        i_clock_gate_n,
   input wire logic                        i_chip_select_low_first,
   input wire logic                        i_chip_select_high,
   input wire logic                        i_chip_select_low_second,
   input wire logic                        i_out_enable_n,
   input wire logic                        i_sleep_request,
   // watched outputs
   input wire logic [sfsp_pkg::DATA_W-1:0] o_dq,
   input wire logic                        o_dq_oe,
   input wire logic                        o_parity_io_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic qual;
   logic sel;
   // an edge the port acts on, and the one select pattern
   assign qual = !i_clock_gate_n && !i_sleep_request;
   assign sel  = !i_chip_select_low_first && i_chip_select_high && !i_chip_select_low_second;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_oe_gated: assert property (o_dq_oe |-> !i_out_enable_n && !i_sleep_request)
      else $error("data drive without enable");
   a_parity_pair: assert property (o_parity_io_oe == o_dq_oe)
      else $error("parity drive differs");
   a_gate_hold: assert property (i_clock_gate_n |=> $stable(o_dq))
      else $error("data moved on gated edge");
   a_sleep_hold: assert property (i_sleep_request |=> $stable(o_dq))
      else $error("data moved in sleep");
   a_desel_hiz: assert property (qual && !sel |=> !o_dq_oe)
      else $error("drive after deselect");
   a_write_hiz: assert property (qual && sel && !i_burst_step_or_load && !i_write_n
      |=> !o_dq_oe)
      else $error("drive in write data phase");
   a_read_drive: assert property (qual && sel && !i_burst_step_or_load && i_write_n
      ##1 !i_out_enable_n && !i_sleep_request |-> o_dq_oe)
      else $error("read not driven");
   a_idle_step: assert property (qual && !sel ##1 qual && sel && i_burst_step_or_load
      |=> !o_dq_oe)
      else $error("advance while idle drove");
endmodule
bind sfsp_port sfsp_port_monitor u_sfsp_port_monitor (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_write_n(i_write_n),
   .i_burst_step_or_load(i_burst_step_or_load), .i_clock_gate_n(i_clock_gate_n),
   .i_chip_select_low_first(i_chip_select_low_first), .i_chip_select_high(i_chip_select_high),
   .i_chip_select_low_second(i_chip_select_low_second), .i_out_enable_n(i_out_enable_n),
   .i_sleep_request(i_sleep_request), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
   .o_parity_io_oe(o_parity_io_oe)
);

//--- test/sfsp_ctrl_model.sv
module sfsp_ctrl_model (
   // clock
   input  wire logic                   i_clk,
   // controls toward the port, selects as {low first, high, low second}
   output logic [sfsp_pkg::ADDR_W-1:0] o_addr,
   output logic                        o_write_n,
   output logic                        o_step,
   output logic                        o_gate_n,
   output logic [3:0]                  o_bw_n,
   output logic [2:0]                  o_cs,
   // write data, parity in the top four bits
   output logic [35:0]                 o_wd
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        act;
   logic        wburst;
   logic        pend;
   logic [35:0] pdata;
   // quiet start: deselected, no burst open
   initial
   begin
      {o_addr, o_write_n, o_step, o_gate_n, o_bw_n, o_cs} = {18'h0, 3'h4, 4'hf, 3'h0};
      {o_wd, pdata, act, wburst, pend} = '0;
   end
   // one bus cycle, launched just after the edge
   task automatic cmd(input logic [2:0] cs, input logic adv, input logic wn,
                      input logic [3:0] bw, input logic [17:0] a, input logic [35:0] wd);
      @(posedge i_clk);
      #1;
      // data one edge late; a released bus keeps toggling
      o_wd = pend ? pdata : ~o_wd;
      if (cs != 3'h2)
         act = 1'b0;
      else if (!adv)
      begin
         act = 1'b1;
         wburst = !wn;
      end
      pend = act && wburst;
      pdata = wd;
      // low strobe asks for a write
      {o_cs, o_step, o_write_n, o_bw_n, o_addr, o_gate_n} = {cs, adv, wn, bw, a, 1'b0};
   endtask
   // gated edges carrying a write load that must come to nothing
   task automatic hold(input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         #1;
         {o_gate_n, o_write_n, o_step, o_addr} = {3'h4, ~o_addr};
      end
   endtask
endmodule

//--- test/sfsp_port_tb.sv
module sfsp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, arst_n, oe_n, sleep, order, write_n, step, gate_n, dq_oe, par_oe;
   logic [17:0] addr;
   logic [3:0]  bw_n, par_in, par_out;
   logic [2:0]  cs;
   logic [35:0] wd;
   logic [31:0] dq_in, dq_out;
   int          mismatches, n_checks;
   // pin level: the port wins while it drives
   assign dq_in  = dq_oe ? dq_out : wd[31:0];
   assign par_in = par_oe ? par_out : wd[35:32];
   sfsp_port u_sfsp_port (
      .i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_write_n(write_n),
      .i_burst_step_or_load(step), .i_clock_gate_n(gate_n), .i_byte_write_n(bw_n),
      .i_chip_select_low_first(cs[2]), .i_chip_select_high(cs[1]),
      .i_chip_select_low_second(cs[0]), .i_out_enable_n(oe_n), .i_sleep_request(sleep),
      .i_burst_order(order), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe),
      .i_parity_io(par_in), .o_parity_io(par_out), .o_parity_io_oe(par_oe));
   sfsp_ctrl_model u_sfsp_ctrl_model (
      .i_clk(clk), .o_addr(addr), .o_write_n(write_n), .o_step(step), .o_gate_n(gate_n),
      .o_bw_n(bw_n), .o_cs(cs), .o_wd(wd));
   // stored word made from its own address, so every location differs
   function automatic logic [35:0] w(input logic [17:0] a);
      return {a[3:0], a[13:0], a};
   endfunction
   function automatic logic [17:0] baddr(input logic ord, input logic [17:0] s, input int n);
      return {s[17:2], ord ? s[1:0] ^ n[1:0] : s[1:0] + n[1:0]};
   endfunction
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic seen(input logic [17:0] a);
      chk("read data", w(a), {par_out, dq_out});
   endtask
   task automatic op(input logic [2:0] c, input logic adv, input logic wn, input logic [17:0] a);
      u_sfsp_ctrl_model.cmd(c, adv, wn, 4'h0, a, w(a));
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // write a whole burst, read it back with one wrap beat
   task automatic t_burst(input logic ord, input logic [17:0] s);
      order = ord;
      for (int n = 0; n < 4; n++)
         op(3'h2, n != 0, 1'b0, baddr(ord, s, n));
      for (int n = 0; n < 6; n++)
      begin
         op(n < 5 ? 3'h2 : 3'h0, n != 0, 1'b1, baddr(ord, s, n));
         if (n > 0)
            seen(baddr(ord, s, n - 1));
      end
   endtask
   // lanes 1 and 3 only, read at the very data edge
   task automatic t_lanes(input logic [17:0] a);
      u_sfsp_ctrl_model.cmd(3'h2, 1'b0, 1'b0, 4'h5, a, ~w(a));
      op(3'h2, 1'b0, 1'b1, a);
      op(3'h0, 1'b0, 1'b1, a);
      chk("lane write", w(a) ^ {4'ha, 32'hff00ff00}, {par_out, dq_out});
   endtask
   // gated edges with a write on the pins change nothing
   task automatic t_gate(input logic [17:0] s);
      order = 1'b0;
      op(3'h2, 1'b0, 1'b1, s);
      u_sfsp_ctrl_model.hold(3);
      seen(s);
      op(3'h2, 1'b1, 1'b1, s);
      op(3'h0, 1'b0, 1'b1, s);
      seen(baddr(1'b0, s, 1));
   endtask
   // every other select pattern, then an advance while idle
   task automatic t_desel(input logic [17:0] a);
      for (int c = 0; c < 8; c++)
         if (c != 2)
         begin
            op(3'h2, 1'b0, 1'b1, a);
            op(c[2:0], 1'b0, 1'b1, a);
            seen(a);
            op(3'h2, 1'b1, 1'b1, a);
            chk("oe after deselect", 36'h0, {35'h0, dq_oe});
            op(3'h0, 1'b0, 1'b1, a);
            chk("oe after idle step", 36'h0, {35'h0, dq_oe});
         end
   endtask
   // output enable and sleep act at once; sleep keeps contents
   task automatic t_async(input logic [17:0] a);
      op(3'h2, 1'b0, 1'b1, a);
      u_sfsp_ctrl_model.hold(2);
      oe_n = 1'b1;
      #1;
      chk("oe disabled", 36'h0, {35'h0, dq_oe});
      // keep the usual launch delay after the edge for the sleep pin too
      @(posedge clk);
      #1;
      {oe_n, sleep} = 2'h1;
      #1;
      chk("oe in sleep", 36'h0, {35'h0, dq_oe});
      seen(a);
      u_sfsp_ctrl_model.cmd(3'h2, 1'b0, 1'b0, 4'h0, a, ~w(a));
      op(3'h2, 1'b0, 1'b1, a);
      sleep = 1'b0;
      op(3'h2, 1'b0, 1'b1, a);
      op(3'h0, 1'b0, 1'b1, a);
      seen(a);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // free running clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // guard against a hang
   initial
   begin
      #100000;
      mismatches++;
      complete_run;
   end
   // main sequence
   initial
   begin
      {oe_n, sleep, order, arst_n} = 4'h2;
      mismatches = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      #1;
      chk("reset outputs", 36'h0, {par_out, dq_out});
      chk("reset oe", 36'h0, {35'h0, dq_oe});
      arst_n = 1'b1;
      t_burst(1'b0, 18'h3fff1);
      t_burst(1'b1, 18'h00021);
      t_lanes(18'h3fff1);
      t_gate(18'h00020);
      t_desel(18'h3fff2);
      t_async(18'h00022);
      complete_run;
   end
endmodule
